// ### src/sbfpa_pkg.sv
// Shared constants for the pulse-addressed polling link, both ends.
// Operation
// - Function chosen by host low-pulse width and message mode
// - Addressed match waits seven ticks before frame
// - Keep 70.4 us from pulse rise to sync end
// - Output request returns held data, else live
// - Zero-slot option samples on slot-0 output request
// - No-sample without zero-slot never holds data
// - Sample request captures data unless no-sample set
// - Sample addressing option makes sample request respond
// - All sensors should share sampling configuration
// - Synchronize pulse makes next addressing slot zero
// - Short trigger windows 15-19, 31-39, 93-115
// - Long trigger windows 9-81 and 105-171
// - Host sends zero to three increment pulses
// - Eighteen high ticks end increments; match identifier
// - Addressed mode windows 15-19 and 31-39
// - Sync polling counts addressing pulses, matches identifier
// - Slot counter wraps past configured sensor count
// - Broadcast pulses leave slot counter unchanged
// - Slot marking delays 7, 18, 36, 62 ticks
package sbfpa_pkg;

    // ========================================================
    // Timing.
    localparam int CLK_NS = 20;
    localparam int TICK_NS = 3000;
    localparam int TICK_CYC = TICK_NS / CLK_NS;
    localparam int RESP_MIN_NS = 70400;
    localparam int RESP_MIN_CYC = (RESP_MIN_NS + CLK_NS - 1) / CLK_NS;
    localparam int SYNC_PULSE_TICKS = 56;

    // ========================================================
    // Message modes.
    localparam logic [2:0] MODE_LONG = 3'h3;
    localparam logic [2:0] MODE_SHORT = 3'h4;
    localparam logic [2:0] MODE_ADDRESSED = 3'h5;

    // ========================================================
    // Pulse windows in ticks.
    localparam logic [7:0] S_OUT_MIN = 8'h0f;
    localparam logic [7:0] S_OUT_NOM = 8'h11;
    localparam logic [7:0] S_OUT_MAX = 8'h13;
    localparam logic [7:0] S_SMP_MIN = 8'h1f;
    localparam logic [7:0] S_SMP_NOM = 8'h23;
    localparam logic [7:0] S_SMP_MAX = 8'h27;
    localparam logic [7:0] S_SYN_MIN = 8'h5d;
    localparam logic [7:0] S_SYN_NOM = 8'h68;
    localparam logic [7:0] S_SYN_MAX = 8'h73;
    localparam logic [7:0] L_OUT_MIN = 8'h09;
    localparam logic [7:0] L_OUT_NOM = 8'h2d;
    localparam logic [7:0] L_OUT_MAX = 8'h51;
    localparam logic [7:0] L_SYN_MIN = 8'h69;
    localparam logic [7:0] L_SYN_NOM = 8'h8c;
    localparam logic [7:0] L_SYN_MAX = 8'hab;
    localparam logic [7:0] INC_END_TICKS = 8'h12;
    localparam logic [7:0] INC_LOW_TICKS = 8'h03;
    localparam logic [7:0] INC_GAP_TICKS = 8'h03;
    localparam logic [7:0] RESP_DLY_TICKS = 8'h07;
    localparam logic [7:0] MARK_DLY0 = 8'h07;
    localparam logic [7:0] MARK_DLY1 = 8'h12;
    localparam logic [7:0] MARK_DLY2 = 8'h24;
    localparam logic [7:0] MARK_DLY3 = 8'h3e;

    // ========================================================
    // Host command port.
    localparam logic [1:0] REG_CTRL = 2'h0;
    localparam logic [1:0] REG_MODE = 2'h1;
    localparam logic [1:0] REG_STATUS = 2'h2;
    localparam logic [1:0] FN_OUTPUT = 2'h0;
    localparam logic [1:0] FN_SAMPLE = 2'h1;
    localparam logic [1:0] FN_SYNC = 2'h2;

endpackage

// ### src/sbfpa_if.sv
// Shared open-drain polling line between host and one sensor end.
`timescale 1ns/100ps
interface sbfpa_if;
    logic host_out;
    logic host_oe_n;
    logic dev_out;
    logic dev_oe_n;
    logic line;

    // The line is pulled high unless an enabled end drives it low.
    assign line = ~((~host_oe_n & ~host_out) | (~dev_oe_n & ~dev_out));

    modport dev (input line, output dev_out, output dev_oe_n);
    modport host (input line, output host_out, output host_oe_n);
endinterface

// ### src/sbfpa_device.sv
// Sensor end: decodes host function pulses and schedules the reply.
`timescale 1ns/100ps
module sbfpa_device
    import sbfpa_pkg::*;
#(
    parameter int TICK_CYCLES = TICK_CYC
) (
    input wire logic clock, // System clock.
    input wire logic srst, // Synchronous reset.
    sbfpa_if.dev bus, // Shared line.
    input wire logic [2:0] output_message_select, // Message mode.
    input wire logic cfg_zero_sample, // Hold on slot-0 output.
    input wire logic cfg_no_sample, // Never hold on sample.
    input wire logic sample_pulse_addresses, // Sample also addresses.
    input wire logic cfg_slot_marking, // Per-id reply delay.
    input wire logic [1:0] cfg_max_sensor, // Last slot index.
    input wire logic [1:0] bus_identifier, // Own identifier.
    input wire logic [15:0] live_data, // Current field data.
    input wire logic tx_low, // Encoder pulls line low.
    input wire logic frame_done, // Encoder finished frame.
    output logic frame_start, // Pulse: begin frame.
    output logic [15:0] frame_data, // Data for the frame.
    output logic [1:0] poll_position_count, // Slot counter.
    output logic [1:0] id_increment_count // Increments seen.
);

    // ========================================================
    // State and registers.
    typedef enum logic [3:0] {
        ST_IDLE = 4'h1,
        ST_INC = 4'h2,
        ST_WAIT = 4'h4,
        ST_SEND = 4'h8
    } sbfpa_dev_state_type;

    localparam int SYNC_CYC = SYNC_PULSE_TICKS * TICK_CYCLES;

    sbfpa_dev_state_type state;
    sbfpa_dev_state_type next_state;
    logic line_q;
    logic [15:0] pre_cnt;
    logic [7:0] tick_cnt;
    logic [16:0] fn_cyc;
    logic [15:0] held;
    logic held_valid;

    // ========================================================
    // Edge and width decode.
    wire line_now = bus.line;
    wire rise = line_now & ~line_q;
    wire fall = ~line_now & line_q;
    wire is_long = output_message_select == MODE_LONG;
    wire is_short = output_message_select == MODE_SHORT;
    wire is_addr = output_message_select == MODE_ADDRESSED;
    wire idle = state == ST_IDLE;
    wire tick_wrap = pre_cnt == 16'(TICK_CYCLES - 1);

    wire win_s_out = tick_cnt >= S_OUT_MIN && tick_cnt <= S_OUT_MAX;
    wire win_s_smp = tick_cnt >= S_SMP_MIN && tick_cnt <= S_SMP_MAX;
    wire win_s_syn = tick_cnt >= S_SYN_MIN && tick_cnt <= S_SYN_MAX;
    wire win_l_out = tick_cnt >= L_OUT_MIN && tick_cnt <= L_OUT_MAX;
    wire win_l_syn = tick_cnt >= L_SYN_MIN && tick_cnt <= L_SYN_MAX;

    // Function is known only at the rising edge, from width and message mode.
    wire f_out = idle & rise & ((is_long & win_l_out)
        | ((is_short | is_addr) & win_s_out));
    wire f_smp = idle & rise & (is_short | is_addr) & win_s_smp;
    wire f_syn = idle & rise & ((is_long & win_l_syn)
        | (is_short & win_s_syn));

    wire addressing = f_out | (f_smp & sample_pulse_addresses);
    wire slot_hit = poll_position_count == bus_identifier;
    wire slot_last = poll_position_count == cfg_max_sensor;
    wire zero_cap = f_out & cfg_zero_sample & ~is_addr
        & (poll_position_count == 2'h0);
    wire smp_cap = f_smp & ~cfg_no_sample;
    wire capture = zero_cap | smp_cap;

    wire [7:0] mark_dly = (bus_identifier == 2'h0) ? MARK_DLY0
        : (bus_identifier == 2'h1) ? MARK_DLY1
        : (bus_identifier == 2'h2) ? MARK_DLY2 : MARK_DLY3;
    wire [7:0] need_ticks = (cfg_slot_marking & ~is_addr)
        ? mark_dly : RESP_DLY_TICKS;
    wire cyc_ok = (fn_cyc + 17'(SYNC_CYC)) >= 17'(RESP_MIN_CYC);
    wire go = line_now & (tick_cnt >= need_ticks) & cyc_ok;
    wire inc_end = line_now & (tick_cnt >= INC_END_TICKS);
    wire id_match = id_increment_count == bus_identifier;

    // ========================================================
    // Next state.
    always_comb begin
        next_state = state;
        case (state)
            ST_IDLE: begin
                if (addressing & is_addr) begin
                    next_state = ST_INC;
                end else if (addressing & slot_hit) begin
                    next_state = ST_WAIT;
                end
            end
            ST_INC: begin
                if (inc_end) begin
                    next_state = id_match ? ST_WAIT : ST_IDLE;
                end
            end
            ST_WAIT: begin
                if (~line_now) begin
                    next_state = ST_IDLE;
                end else if (go) begin
                    next_state = ST_SEND;
                end
            end
            ST_SEND: begin
                if (frame_done) begin
                    next_state = ST_IDLE;
                end
            end
            default: begin
                next_state = ST_IDLE;
            end
        endcase
    end

    // ========================================================
    // Width measurement: ticks since the last edge, saturating.
    always_ff @(posedge clock) begin
        if (srst) begin
            line_q <= 1'b1;
            pre_cnt <= 16'h0000;
            tick_cnt <= 8'h00;
        end else begin
            line_q <= line_now;
            // An edge is seen one clock late, so that clock already counts.
            // The tick period must therefore be at least two clocks.
            if (rise | fall) begin
                pre_cnt <= 16'h0001;
            end else if (tick_wrap) begin
                pre_cnt <= 16'h0000;
            end else begin
                pre_cnt <= pre_cnt + 16'h0001;
            end
            if (rise | fall) begin
                tick_cnt <= 8'h00;
            end else if (tick_wrap && tick_cnt != 8'hff) begin
                tick_cnt <= tick_cnt + 8'h01;
            end
        end
    end

    // Cycles since the rising edge of the last addressing function pulse.
    always_ff @(posedge clock) begin
        if (srst) begin
            fn_cyc <= 17'h1ffff;
        end else if (addressing) begin
            fn_cyc <= 17'h00000;
        end else if (fn_cyc != 17'h1ffff) begin
            fn_cyc <= fn_cyc + 17'h00001;
        end
    end

    // ========================================================
    // Slot counter and increment counter.
    always_ff @(posedge clock) begin
        if (srst) begin
            poll_position_count <= 2'h0;
        end else if (f_syn) begin
            poll_position_count <= 2'h0;
        end else if (addressing & ~is_addr) begin
            poll_position_count <= slot_last ? 2'h0
                : poll_position_count + 2'h1;
        end
    end

    always_ff @(posedge clock) begin
        if (srst) begin
            id_increment_count <= 2'h0;
        end else if (addressing & is_addr) begin
            id_increment_count <= 2'h0;
        end else if (state == ST_INC && fall
            && id_increment_count != 2'h3) begin
            id_increment_count <= id_increment_count + 2'h1;
        end
    end

    // ========================================================
    // Sample-and-hold and reply data.
    always_ff @(posedge clock) begin
        if (srst) begin
            held <= 16'h0000;
            held_valid <= 1'b0;
        end else if (capture) begin
            held <= live_data;
            held_valid <= 1'b1;
        end else if (frame_start) begin
            held_valid <= 1'b0;
        end
    end

    always_ff @(posedge clock) begin
        if (srst) begin
            frame_start <= 1'b0;
            frame_data <= 16'h0000;
        end else begin
            frame_start <= (state == ST_WAIT) & go;
            if ((state == ST_WAIT) & go) begin
                frame_data <= held_valid ? held : live_data;
            end
        end
    end

    // ========================================================
    // Line driver: low only while the encoder asks, in a reply.
    always_ff @(posedge clock) begin
        if (srst) begin
            bus.dev_out <= 1'b0;
            bus.dev_oe_n <= 1'b1;
            state <= ST_IDLE;
        end else begin
            bus.dev_out <= 1'b0;
            bus.dev_oe_n <= ~(tx_low & (state == ST_SEND));
            state <= next_state;
        end
    end

endmodule

// ### src/sbfpa_host.sv
// Host end: drives function and increment pulses from a command port.
`timescale 1ns/100ps
module sbfpa_host
    import sbfpa_pkg::*;
#(
    parameter int TICK_CYCLES = TICK_CYC
) (
    input wire logic clock, // System clock.
    input wire logic srst, // Synchronous reset.
    sbfpa_if.host bus, // Shared line.
    input wire logic [1:0] addr, // Register address.
    input wire logic [7:0] wdata, // Write data.
    input wire logic wr, // Write strobe.
    input wire logic rd, // Read strobe.
    output logic [7:0] rdata // Read data, next cycle.
);

    typedef enum logic [3:0] {
        HS_IDLE = 4'h1,
        HS_LOW = 4'h2,
        HS_GAP = 4'h4,
        HS_INC = 4'h8
    } sbfpa_host_state_type;

    sbfpa_host_state_type state;
    logic [2:0] output_message_select;
    logic [1:0] incs_left;
    logic [15:0] pre_cnt;
    logic [7:0] ticks;
    logic resp_seen;
    logic line_q;

    // ========================================================
    // Decode.
    wire wr_ctrl = wr & (addr == REG_CTRL);
    wire wr_mode = wr & (addr == REG_MODE);
    wire wr_stat = wr & (addr == REG_STATUS);
    wire [1:0] fn = wdata[1:0];
    wire is_long = output_message_select == MODE_LONG;
    wire is_addr = output_message_select == MODE_ADDRESSED;
    wire fn_ok = (fn == FN_OUTPUT) | (fn == FN_SYNC)
        | ((fn == FN_SAMPLE) & ~is_long);
    wire start = wr_ctrl & fn_ok & (state == HS_IDLE);
    wire [7:0] width = (fn == FN_SYNC) ? (is_long ? L_SYN_NOM : S_SYN_NOM)
        : (fn == FN_SAMPLE) ? S_SMP_NOM
        : (is_long ? L_OUT_NOM : S_OUT_NOM);
    wire tick_wrap = pre_cnt == 16'(TICK_CYCLES - 1);
    wire at_end = tick_wrap & (ticks == 8'h01);
    wire dev_low = ~bus.line & line_q & bus.host_oe_n
        & (state == HS_IDLE);

    // ========================================================
    // Pulse sequencer: ticks counts down the current phase.
    always_ff @(posedge clock) begin
        if (srst) begin
            state <= HS_IDLE;
            ticks <= 8'h00;
            pre_cnt <= 16'h0000;
            incs_left <= 2'h0;
            bus.host_out <= 1'b0;
            bus.host_oe_n <= 1'b1;
        end else if (start) begin
            state <= HS_LOW;
            ticks <= width;
            pre_cnt <= 16'h0000;
            incs_left <= (is_addr & (fn != FN_SYNC)) ? wdata[3:2] : 2'h0;
            bus.host_oe_n <= 1'b0;
        end else if (state != HS_IDLE) begin
            pre_cnt <= tick_wrap ? 16'h0000 : pre_cnt + 16'h0001;
            if (tick_wrap) begin
                ticks <= ticks - 8'h01;
            end
            if (at_end) begin
                case (state)
                    HS_LOW, HS_INC: begin
                        bus.host_oe_n <= 1'b1;
                        state <= (incs_left != 2'h0) ? HS_GAP : HS_IDLE;
                        ticks <= INC_GAP_TICKS;
                    end
                    HS_GAP: begin
                        bus.host_oe_n <= 1'b0;
                        incs_left <= incs_left - 2'h1;
                        state <= HS_INC;
                        ticks <= INC_LOW_TICKS;
                    end
                    default: begin
                        state <= HS_IDLE;
                    end
                endcase
            end
        end
    end

    // ========================================================
    // Registers: mode select and sticky reply flag.
    always_ff @(posedge clock) begin
        if (srst) begin
            output_message_select <= MODE_SHORT;
            resp_seen <= 1'b0;
            line_q <= 1'b1;
            rdata <= 8'h00;
        end else begin
            line_q <= bus.line;
            if (wr_mode) begin
                output_message_select <= wdata[2:0];
            end
            // A reply edge in the clearing cycle wins.
            if (dev_low) begin
                resp_seen <= 1'b1;
            end else if (wr_stat & wdata[1]) begin
                resp_seen <= 1'b0;
            end
            if (rd) begin
                case (addr)
                    REG_MODE: rdata <= {5'h00, output_message_select};
                    REG_STATUS: rdata <= {6'h00, resp_seen,
                        state != HS_IDLE};
                    default: rdata <= 8'h00;
                endcase
            end else begin
                rdata <= 8'h00;
            end
        end
    end

endmodule

// ### tb/sbfpa_properties.sv
// Concurrent checks on the shared polling line and the sensor reply.
`timescale 1ns/100ps
module sbfpa_properties
    import sbfpa_pkg::*;
#(
    parameter int TICK_CYCLES = TICK_CYC
) (
    input wire logic clock, // Clock.
    input wire logic srst, // Reset.
    input wire logic host_out, // Host pin value.
    input wire logic host_oe_n, // Host enable.
    input wire logic dev_out, // Sensor pin value.
    input wire logic dev_oe_n, // Sensor enable.
    input wire logic line, // Line level.
    input wire logic frame_start // Frame pulse.
);
    localparam int T = TICK_CYCLES;
    logic [15:0] low_cnt;
    logic [15:0] high_cnt;
    logic [15:0] since_fn;
    wire logic rise = host_oe_n && low_cnt != 16'h0000;
    wire logic fn_rise = rise && low_cnt >= 16'(9 * T);
    wire logic width_ok = low_cnt == 16'(3 * T)
        || (low_cnt >= 16'(9 * T) && low_cnt <= 16'(81 * T))
        || (low_cnt >= 16'(93 * T) && low_cnt <= 16'(171 * T));

    // ==========================================================
    // Host low time, line high time and time since a function rise.
    always_ff @(posedge clock) begin
        if (srst) begin
            low_cnt <= 16'h0000;
            high_cnt <= 16'h0000;
            since_fn <= 16'hffff;
        end else begin
            low_cnt <= host_oe_n ? 16'h0000 : low_cnt + 16'h0001;
            high_cnt <= !line ? 16'h0000
                : high_cnt + 16'(high_cnt != 16'hffff);
            since_fn <= fn_rise ? 16'h0001
                : since_fn + 16'(since_fn != 16'hffff);
        end
    end

    // ==========================================================
    // Assertions.
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (srst);

    property p_open_drain;
        !host_out && !dev_out;
    endproperty
    a_open_drain: assert property (p_open_drain)
        else $error("line pin driven high");
    property p_host_width;
        rise |-> width_ok;
    endproperty
    a_host_width: assert property (p_host_width)
        else $error("host pulse width outside windows");
    property p_reply_gap;
        frame_start |-> line && high_cnt >= 16'(7 * T - 1);
    endproperty
    a_reply_gap: assert property (p_reply_gap)
        else $error("reply started too soon");
    property p_reply_time;
        frame_start |-> since_fn + 56 * T + 2 >= RESP_MIN_CYC;
    endproperty
    a_reply_time: assert property (p_reply_time)
        else $error("reply ends sync too early");
    property p_start_pulse;
        frame_start |=> !frame_start ##1 !frame_start;
    endproperty
    a_start_pulse: assert property (p_start_pulse)
        else $error("frame start repeated");
    property p_drive_gap;
        $fell(dev_oe_n) |-> $past(high_cnt) >= 16'(7 * T - 1);
    endproperty
    a_drive_gap: assert property (p_drive_gap)
        else $error("sensor pulled line without high gap");
    property p_host_quiet;
        !dev_oe_n |-> host_oe_n;
    endproperty
    a_host_quiet: assert property (p_host_quiet)
        else $error("host drives during reply");
    property p_dev_quiet;
        !host_oe_n |-> dev_oe_n;
    endproperty
    a_dev_quiet: assert property (p_dev_quiet)
        else $error("sensor drives during host pulse");
endmodule

// ### tb/testbench.sv
// Self-checking bench for the host and sensor ends of the polling link.
`timescale 1ns/100ps
module testbench
    import sbfpa_pkg::*;
;
    localparam int TK = 4;
    logic clock = 1'b0;
    logic srst = 1'b1;
    logic [1:0] addr = 2'h0;
    logic [7:0] wdata = 8'h00;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic [7:0] rdata;
    logic [2:0] mode = MODE_SHORT;
    logic zs = 1'b0;
    logic ns = 1'b0;
    logic sa = 1'b0;
    logic mark = 1'b0;
    logic [1:0] maxs = 2'h2;
    logic [1:0] ident = 2'h1;
    logic [15:0] live = 16'h0000;
    logic tx_low = 1'b0;
    logic frame_done = 1'b0;
    logic h2_oe_n = 1'b1;
    logic frame_start;
    logic [15:0] frame_data;
    logic [1:0] slot;
    logic [1:0] incs;
    logic [1:0] slot2;
    logic [3:0] fr_tmr = 4'h0;
    logic [15:0] got = 16'h0000;
    logic [1:0] es = 2'h0;
    logic [1:0] e2 = 2'h0;
    logic [15:0] held = 16'h0000;
    logic hv = 1'b0;
    logic [7:0] sv;
    int replies = 0;
    int miscompares = 0;
    int checked = 0;
    int seed = 69;
    int widths[15] = '{93, 15, 14, 19, 20, 31, 39, 40, 92, 15, 116, 15,
        115, 30, 16};

    sbfpa_if bus ();
    sbfpa_if bus2 ();
    assign bus2.host_out = 1'b0;
    assign bus2.host_oe_n = h2_oe_n;

    always #10 clock = ~clock;

    sbfpa_host #(.TICK_CYCLES(TK)) sbfpa_host_inst (.clock(clock),
        .srst(srst), .bus(bus), .addr(addr), .wdata(wdata), .wr(wr),
        .rd(rd), .rdata(rdata));
    sbfpa_device #(.TICK_CYCLES(TK)) sbfpa_device_inst (.clock(clock),
        .srst(srst), .bus(bus), .output_message_select(mode),
        .cfg_zero_sample(zs), .cfg_no_sample(ns),
        .sample_pulse_addresses(sa), .cfg_slot_marking(mark),
        .cfg_max_sensor(maxs), .bus_identifier(ident), .live_data(live),
        .tx_low(tx_low), .frame_done(frame_done),
        .frame_start(frame_start), .frame_data(frame_data),
        .poll_position_count(slot), .id_increment_count(incs));
    sbfpa_device #(.TICK_CYCLES(TK)) sbfpa_device_inst2 (.clock(clock),
        .srst(srst), .bus(bus2), .output_message_select(mode),
        .cfg_zero_sample(zs), .cfg_no_sample(ns),
        .sample_pulse_addresses(sa), .cfg_slot_marking(mark),
        .cfg_max_sensor(maxs), .bus_identifier(2'h3), .live_data(live),
        .tx_low(tx_low), .frame_done(frame_done), .frame_start(),
        .frame_data(), .poll_position_count(slot2),
        .id_increment_count());
    sbfpa_properties #(.TICK_CYCLES(TK)) sbfpa_properties_inst (
        .clock(clock), .srst(srst), .host_out(bus.host_out),
        .host_oe_n(bus.host_oe_n), .dev_out(bus.dev_out),
        .dev_oe_n(bus.dev_oe_n), .line(bus.line),
        .frame_start(frame_start));

    // Stands in for the frame encoder: a short low burst, then done.
    always @(posedge clock) begin
        if (frame_start === 1'b1) begin
            replies <= replies + 1;
            got <= frame_data;
            fr_tmr <= 4'h6;
        end else if (fr_tmr != 4'h0) begin
            fr_tmr <= fr_tmr - 4'h1;
        end
        tx_low <= fr_tmr >= 4'h3 && fr_tmr <= 4'h5;
        frame_done <= fr_tmr == 4'h2;
    end

    function automatic logic [1:0] nxt(input logic [1:0] c);
        return (c == maxs) ? 2'h0 : c + 2'h1;
    endfunction
    function automatic logic [1:0] win(input int w);
        if (w >= S_OUT_MIN && w <= S_OUT_MAX) return FN_OUTPUT;
        if (w >= S_SMP_MIN && w <= S_SMP_MAX) return FN_SAMPLE;
        if (w >= S_SYN_MIN && w <= S_SYN_MAX) return FN_SYNC;
        return 2'h3;
    endfunction

    task automatic check(input logic [15:0] seen, input logic [15:0] want);
        checked++;
        if (seen !== want) begin
            miscompares++;
            $display("wrong value at %0t: %h, expected %h", $time, seen,
                want);
        end
    endtask
    task automatic close_out;
        $display("checked %0d, miscompares %0d", checked, miscompares);
        if (miscompares == 0 && checked > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    task automatic wr_reg(input logic [1:0] a, input logic [7:0] d);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clock);
        wr <= 1'b0;
        @(posedge clock);
    endtask
    task automatic rd_reg(input logic [1:0] a, output logic [7:0] d);
        addr <= a;
        rd <= 1'b1;
        @(posedge clock);
        rd <= 1'b0;
        #1;
        d = rdata;
        @(posedge clock);
    endtask
    task automatic pulse2(input int w);
        h2_oe_n <= 1'b0;
        repeat (w * TK) @(posedge clock);
        h2_oe_n <= 1'b1;
        repeat (4 * TK) @(posedge clock);
        if (win(w) == FN_SYNC) e2 = 2'h0;
        else if (win(w) == FN_OUTPUT) e2 = nxt(e2);
        check({14'h0, slot2}, {14'h0, e2});
    endtask
    task automatic run(input logic [1:0] fn, input logic [1:0] inc);
        int n0;
        logic adr;
        logic hit;
        n0 = replies;
        live <= 16'($random(seed));
        wr_reg(REG_CTRL, {4'h0, inc, fn});
        @(posedge clock);
        sv = 8'h01;
        for (int i = 0; i < 600 && sv[0]; i++) rd_reg(REG_STATUS, sv);
        for (int i = 0; i < 3600 && replies == n0; i++) @(posedge clock);
        repeat (20) @(posedge clock);
        adr = fn == FN_OUTPUT || (fn == FN_SAMPLE && sa);
        hit = adr && (mode == MODE_ADDRESSED ? inc == ident : es == ident);
        if (fn == FN_SAMPLE && !ns) begin
            held = live;
            hv = 1'b1;
        end
        if (fn == FN_OUTPUT && zs && mode != MODE_ADDRESSED && es == 0) begin
            held = live;
            hv = 1'b1;
        end
        check(16'(replies - n0), {15'h0, hit});
        rd_reg(REG_STATUS, sv);
        check({14'h0, sv[1:0]}, {14'h0, hit, 1'b0});
        wr_reg(REG_STATUS, 8'h02);
        if (hit) begin
            check(got, hv ? held : live);
            hv = 1'b0;
        end
        if (mode == MODE_ADDRESSED) begin
            check({14'h0, incs}, {14'h0, inc});
        end else begin
            if (fn == FN_SYNC) es = 2'h0;
            else if (adr) es = nxt(es);
            check({14'h0, slot}, {14'h0, es});
        end
    endtask

    initial begin
        #1900000;
        miscompares++;
        close_out();
    end

    initial begin
        repeat (3) @(posedge clock);
        srst <= 1'b0;
        @(posedge clock);
        rd_reg(REG_MODE, sv);
        check({8'h0, sv}, {13'h0, MODE_SHORT});
        foreach (widths[i]) pulse2(widths[i]);
        run(FN_SYNC, 2'h0);
        run(FN_OUTPUT, 2'h0);
        run(FN_OUTPUT, 2'h0);
        run(FN_SAMPLE, 2'h0);
        run(FN_OUTPUT, 2'h0);
        run(FN_OUTPUT, 2'h0);
        run(FN_OUTPUT, 2'h0);
        for (int i = 0; i < 5; i++) begin
            sv = 8'($random(seed));
            ns <= sv[0];
            sa <= sv[1];
            zs <= sv[2];
            mark <= sv[4];
            run(sv[3] ? FN_SAMPLE : FN_OUTPUT, 2'h0);
        end
        zs <= 1'b0;
        wr_reg(REG_MODE, {5'h0, MODE_LONG});
        mode <= MODE_LONG;
        run(FN_SYNC, 2'h0);
        run(FN_OUTPUT, 2'h0);
        run(FN_OUTPUT, 2'h0);
        wr_reg(REG_MODE, {5'h0, MODE_ADDRESSED});
        mode <= MODE_ADDRESSED;
        sa <= 1'b1;
        run(FN_OUTPUT, 2'h1);
        run(FN_OUTPUT, 2'h2);
        run(FN_SAMPLE, 2'h1);
        close_out();
    end
endmodule
